// file: design/fidrw_pkg.sv
// Notes on behaviour
// [R1] 9F returns maker byte then two device bytes
// [R2] AB, three dummy bytes, then device byte
// [R3] 90, dummies, address picks maker or device first
// [R4] B1 enters OTP area, C1 leaves it
// [R5] 2F locks guard bit forever, clears latch
// [R6] host avoids undefined opcodes; device ignores them
// [R7] 99 resets only right after 66
// [R8] lone latch-arm opcode sets write latch
// [R9] host arms latch before each modifying command
// [R10] lone latch-clear opcode clears write latch
// [R11] latch clears on power-up, suspend, completions, reset
// [R12] 24 id bits out, host may stop anytime
// [R13] id opcode ignored while array is busy
// [R14] chip select high returns to standby
// [R15] id bytes start on next falling edge, repeat
// [R16] maker and device bytes alternate while selected
// [R17] signature byte repeats while clocks continue
// [R18] program or erase ignored without write latch
// [R19] opcode is eight bits, msb first, rising edges
package fidrw_pkg;

  // opcodes
  localparam logic [7:0] OP_ID_READ     = 8'h9f;
  localparam logic [7:0] OP_SIG_READ    = 8'hab;
  localparam logic [7:0] OP_MAKER_PART  = 8'h90;
  localparam logic [7:0] OP_OTP_ENTER   = 8'hb1;
  localparam logic [7:0] OP_OTP_LEAVE   = 8'hc1;
  localparam logic [7:0] OP_GUARD_READ  = 8'h2b;
  localparam logic [7:0] OP_GUARD_LOCK  = 8'h2f;
  localparam logic [7:0] OP_REBOOT_ARM  = 8'h66;
  localparam logic [7:0] OP_REBOOT_GO   = 8'h99;
  localparam logic [7:0] OP_LATCH_ARM   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_SUSPEND_A   = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B   = 8'hb0;
  localparam logic [7:0] OP_PAGE_WRITE  = 8'h02;
  localparam logic [7:0] OP_QUAD_WRITE  = 8'h38;
  localparam logic [7:0] OP_SMALL_WIPE  = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE   = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE  = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;

  // counts and positions
  localparam logic [4:0] OPC_LAST_BIT   = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT  = 5'h17;
  localparam logic [2:0] SER_LAST_BIT   = 3'h7;
  localparam logic [1:0] ID_LAST_IDX    = 2'h2;
  localparam int         GUARD_LOCK_POS = 1;

  // values after reset
  localparam logic [2:0] PIN_RST        = 3'h4; // cs_n high, sclk low
  localparam logic       LATCH_RST      = 1'b0;
  localparam logic       OTP_RST        = 1'b0;
  localparam logic       LOCK_RST       = 1'b0;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_HOLD,
    ST_ADDR,
    ST_OUT,
    ST_SKIP
  } fidrw_state_t;

endpackage

// file: design/fidrw_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module fidrw_sync import fidrw_pkg::*; #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // meta is read only by the second stage
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule // fidrw_sync

// file: design/fidrw_ser.sv
`timescale 1ns/1ps
// byte serializer: msb first, one bit per shift strobe
module fidrw_ser import fidrw_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       start,
  input  wire logic       shift,
  input  wire logic [7:0] byte_in,
  // serial out and byte handshake
  output logic            so,
  output logic            taken
);

  logic [7:0] sh;
  logic [2:0] cnt;
  logic [7:0] next_sh;
  logic [2:0] next_cnt;
  logic       next_so;
  logic       next_taken;

  // reload straight after the last bit so the stream has no gap
  always_comb begin
    next_sh    = sh;
    next_cnt   = cnt;
    next_so    = so;
    next_taken = 1'b0;
    if (start) begin
      next_sh    = byte_in;
      next_cnt   = 3'h0;
      next_taken = 1'b1;
    end else if (shift) begin
      next_so  = sh[7];
      next_cnt = 3'(cnt + 3'h1);
      if (cnt == SER_LAST_BIT) begin
        next_sh    = byte_in;
        next_taken = 1'b1;
      end else begin
        next_sh = {sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh    <= 8'h00;
      cnt   <= 3'h0;
      so    <= 1'b0;
      taken <= 1'b0;
    end else begin
      sh    <= next_sh;
      cnt   <= next_cnt;
      so    <= next_so;
      taken <= next_taken;
    end
  end

endmodule // fidrw_ser

// file: design/fidrw_core.sv
`timescale 1ns/1ps
// opcode decoder for id reads, otp mode, guard lock, reset and latch
module fidrw_core import fidrw_pkg::*; #(
  parameter logic [7:0] ID_MAKER  = 8'h5a, // arbitrary value
  parameter logic [7:0] ID_TYPE   = 8'h3c, // arbitrary value
  parameter logic [7:0] ID_DEVICE = 8'h07  // arbitrary value
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // serial pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       si,
  output wire logic       so,
  output logic            so_oe,
  // array engine status
  input  wire logic       busy,
  input  wire logic       op_done,
  // control and status
  output logic            write_latch_flag,
  output logic            otp_mode,
  output logic            guard_lock,
  output logic            soft_reset,
  output logic            prog_go,
  output logic      [7:0] prog_op
);

  logic [2:0]   pins_s;
  logic         cs_s;
  logic         sclk_s;
  logic         si_s;
  logic         cs_d;
  logic         sclk_d;
  logic         rise;
  logic         fall;
  logic         cs_rise;
  logic         exec;
  logic [7:0]   shifted;
  logic         taken;
  logic [7:0]   byte_sel;
  logic         latch_set;
  logic         latch_clr;
  fidrw_state_t st;
  logic [4:0]   cnt;
  logic [7:0]   op;
  logic [7:0]   sh_in;
  logic [1:0]   idx;
  logic         armed;
  logic         ser_start;
  fidrw_state_t next_st;
  logic [4:0]   next_cnt;
  logic [7:0]   next_op;
  logic [7:0]   next_sh_in;
  logic [1:0]   next_idx;
  logic         next_armed;
  logic         next_ser_start;
  logic         next_cs_d;
  logic         next_sclk_d;
  logic         next_oe;
  logic         next_latch;
  logic         next_otp;
  logic         next_lock;
  logic         next_soft_reset;
  logic         next_prog_go;
  logic [7:0]   next_prog_op;
  // pins cross into ref_clk before any decoding
  fidrw_sync #(
    .WIDTH     (3),
    .RESET_VAL (PIN_RST)
  ) u_sync (
    .clk  (ref_clk),
    .rstn (rstn),
    .d    ({cs_n, sclk, si}),
    .q    (pins_s)
  );

  // edges of the host clock seen at 20 MHz; needs sclk below ~5 MHz
  assign cs_s    = pins_s[2];
  assign sclk_s  = pins_s[1];
  assign si_s    = pins_s[0];
  assign rise    = sclk_s & ~sclk_d & ~cs_s;
  assign fall    = ~sclk_s & sclk_d & ~cs_s;
  assign cs_rise = cs_s & ~cs_d;
  assign exec    = cs_rise && (st == ST_HOLD);
  assign shifted = {sh_in[6:0], si_s};

  // answer byte for the current read and byte index
  always_comb begin
    case (op)
      OP_ID_READ: begin
        case (idx)
          2'h0:    byte_sel = ID_MAKER; // R1
          2'h1:    byte_sel = ID_TYPE;
          default: byte_sel = ID_DEVICE;
        endcase
      end
      OP_MAKER_PART: byte_sel = idx[0] ? ID_DEVICE : ID_MAKER; // R16
      OP_SIG_READ:   byte_sel = ID_DEVICE; // R17
      OP_GUARD_READ: byte_sel = 8'(guard_lock) << GUARD_LOCK_POS; // R5
      default:       byte_sel = 8'h00;
    endcase
  end

  fidrw_ser u_ser (
    .clk     (ref_clk),
    .rstn    (rstn),
    .start   (ser_start),
    .shift   (fall & so_oe),
    .byte_in (byte_sel),
    .so      (so),
    .taken   (taken)
  );

  // command sequencing; single-byte commands act on chip select rise
  always_comb begin
    next_st         = st;
    next_cnt        = cnt;
    next_op         = op;
    next_sh_in      = sh_in;
    next_idx        = idx;
    next_armed      = armed;
    next_ser_start  = 1'b0;
    next_cs_d       = cs_s;
    next_sclk_d     = sclk_s;
    next_oe         = so_oe;
    next_otp        = otp_mode;
    next_lock       = guard_lock;
    next_soft_reset = 1'b0;
    next_prog_go    = 1'b0;
    next_prog_op    = prog_op;
    latch_set       = 1'b0;
    latch_clr       = op_done; // R11
    if (cs_s) begin
      // deselect always ends the transfer and drops the drive
      next_st  = ST_CMD; // R14
      next_cnt = 5'h00;
      next_oe  = 1'b0; // R12
      next_idx = 2'h0;
      if (exec) begin
        case (op)
          OP_LATCH_ARM:   latch_set = 1'b1; // R8
          OP_LATCH_CLEAR: latch_clr = 1'b1; // R10
          OP_OTP_ENTER:   next_otp = 1'b1; // R4
          OP_OTP_LEAVE:   next_otp = 1'b0; // R4
          OP_GUARD_LOCK: begin
            next_lock = 1'b1; // R5
            latch_clr = 1'b1; // R5
          end
          OP_REBOOT_ARM:  next_armed = 1'b1; // R7
          OP_REBOOT_GO: begin
            next_armed = 1'b0;
            if (armed) begin
              next_soft_reset = 1'b1; // R7
              next_otp        = 1'b0;
              latch_clr       = 1'b1; // R11
            end
          end
          OP_SUSPEND_A, OP_SUSPEND_B: latch_clr = 1'b1; // R11
          default: ;
        endcase
      end
    end else if (rise) begin
      next_sh_in = shifted;
      next_cnt   = 5'(cnt + 5'h01);
      case (st)
        ST_CMD: begin
          if (cnt == OPC_LAST_BIT) begin
            // full opcode, msb first on rising edges
            next_op  = shifted; // R19
            next_cnt = 5'h00;
            if (shifted != OP_REBOOT_GO) begin
              next_armed = 1'b0; // R7
            end
            case (shifted)
              OP_ID_READ: begin
                if (busy) begin
                  next_st = ST_SKIP; // R13
                end else begin
                  next_st        = ST_OUT; // R15
                  next_ser_start = 1'b1;
                  next_oe        = 1'b1;
                end
              end
              OP_SIG_READ, OP_MAKER_PART: next_st = ST_ADDR; // R2
              OP_GUARD_READ: begin
                next_st        = ST_OUT;
                next_ser_start = 1'b1;
                next_oe        = 1'b1;
              end
              OP_PAGE_WRITE, OP_QUAD_WRITE, OP_SMALL_WIPE,
              OP_HALF_WIPE, OP_BLOCK_WIPE, OP_CHIP_WIPE_A,
              OP_CHIP_WIPE_B, OP_STAT_WRITE: begin
                next_st = ST_SKIP;
                if (write_latch_flag) begin
                  next_prog_go = 1'b1; // R18
                  next_prog_op = shifted;
                end
              end
              OP_LATCH_ARM, OP_LATCH_CLEAR, OP_OTP_ENTER,
              OP_OTP_LEAVE, OP_GUARD_LOCK, OP_REBOOT_ARM,
              OP_REBOOT_GO, OP_SUSPEND_A, OP_SUSPEND_B: begin
                next_st = ST_HOLD;
              end
              // unknown codes are dropped, never decoded further
              default: next_st = ST_SKIP; // R6
            endcase
          end
        end
        // extra clocks spoil a command that must stand alone
        ST_HOLD: next_st = ST_SKIP; // R8
        ST_ADDR: begin
          if (cnt == ADDR_LAST_BIT) begin
            next_st        = ST_OUT; // R2
            next_ser_start = 1'b1;
            next_oe        = 1'b1;
            if (op == OP_MAKER_PART) begin
              next_idx = {1'b0, shifted[0]}; // R3
            end
          end
        end
        ST_OUT, ST_SKIP: next_cnt = cnt;
        default: next_st = ST_SKIP;
      endcase
    end else if (taken) begin
      // step to the byte after the one just loaded; id wraps after three
      next_idx = (op == OP_ID_READ && idx == ID_LAST_IDX) ?
                 2'h0 : 2'(idx + 2'h1); // R15
    end
    // an arm arriving with a clear event wins
    next_latch = latch_set | (write_latch_flag & ~latch_clr);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st               <= ST_CMD;
      cnt              <= 5'h00;
      op               <= 8'h00;
      sh_in            <= 8'h00;
      idx              <= 2'h0;
      armed            <= 1'b0;
      ser_start        <= 1'b0;
      cs_d             <= 1'b1;
      sclk_d           <= 1'b0;
      so_oe            <= 1'b0;
      write_latch_flag <= LATCH_RST; // R11
      otp_mode         <= OTP_RST;
      guard_lock       <= LOCK_RST;
      soft_reset       <= 1'b0;
      prog_go          <= 1'b0;
      prog_op          <= 8'h00;
    end else begin
      st               <= next_st;
      cnt              <= next_cnt;
      op               <= next_op;
      sh_in            <= next_sh_in;
      idx              <= next_idx;
      armed            <= next_armed;
      ser_start        <= next_ser_start;
      cs_d             <= next_cs_d;
      sclk_d           <= next_sclk_d;
      so_oe            <= next_oe;
      write_latch_flag <= next_latch;
      otp_mode         <= next_otp;
      guard_lock       <= next_lock;
      soft_reset       <= next_soft_reset;
      prog_go          <= next_prog_go;
      prog_op          <= next_prog_op;
    end
  end

  // checks on the decoded behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_opcode_in(logic [7:0] code);
    rise && st == ST_CMD && cnt == OPC_LAST_BIT && shifted == code;
  endsequence
  sequence s_exec(logic [7:0] code);
    exec && op == code;
  endsequence
  property p_arm_sets;
    s_exec(OP_LATCH_ARM) |=> write_latch_flag;
  endproperty
  a_arm_sets: assert property (p_arm_sets) // R8
    else $error("latch arm did not set latch");
  property p_clear_clears;
    s_exec(OP_LATCH_CLEAR) |=> !write_latch_flag;
  endproperty
  a_clear_clears: assert property (p_clear_clears) // R10
    else $error("latch clear did not clear latch");
  property p_done_clears;
    op_done && !(exec && op == OP_LATCH_ARM) |=> !write_latch_flag;
  endproperty
  a_done_clears: assert property (p_done_clears) // R11
    else $error("completion left latch set");
  property p_lock_forever;
    s_exec(OP_GUARD_LOCK) |=> guard_lock && !write_latch_flag
      ##1 guard_lock [*8];
  endproperty
  a_lock_forever: assert property (p_lock_forever) // R5
    else $error("guard lock not set or latch not cleared");
  property p_otp_enter;
    s_exec(OP_OTP_ENTER) |=> otp_mode;
  endproperty
  a_otp_enter: assert property (p_otp_enter) // R4
    else $error("otp mode not entered");
  property p_otp_leave;
    s_exec(OP_OTP_LEAVE) |=> !otp_mode;
  endproperty
  a_otp_leave: assert property (p_otp_leave) // R4
    else $error("otp mode not left");
  property p_reset_pair;
    s_exec(OP_REBOOT_GO) |=> soft_reset == $past(armed);
  endproperty
  a_reset_pair: assert property (p_reset_pair) // R7
    else $error("reset accepted without arm or lost");
  property p_busy_no_id;
    s_opcode_in(OP_ID_READ) and busy |=> !so_oe [*2];
  endproperty
  a_busy_no_id: assert property (p_busy_no_id) // R13
    else $error("id answered while busy");
  property p_id_starts;
    s_opcode_in(OP_ID_READ) and !busy |=> so_oe && ser_start;
  endproperty
  a_id_starts: assert property (p_id_starts) // R15
    else $error("id output did not start");
  property p_standby;
    cs_rise |=> !so_oe && st == ST_CMD;
  endproperty
  a_standby: assert property (p_standby) // R14
    else $error("no standby after deselect");
  property p_prog_gated;
    prog_go |-> $past(write_latch_flag);
  endproperty
  a_prog_gated: assert property (p_prog_gated) // R18
    else $error("program passed without latch");
endmodule // fidrw_core

// file: testbench/fidrw_host.sv
`timescale 1ns/1ps
// serial host model: mode 0, sclk idles low, 8 ref_clk per sclk period
module fidrw_host (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // data line is not held between frames, so it keeps changing
  always @(posedge ref_clk) begin
    if (cs_n) begin
      si <= ~si;
    end
  end

  // one frame: n_out bits out msb first, then n_in bits in, then cs_n high
  task automatic xfer(input logic [31:0] dout, input int n_out,
                      input int n_in, output logic [31:0] din,
                      output logic oe_seen);
    din     = '0;
    oe_seen = 1'b0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = n_out - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      si   <= dout[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    // sample just before the next falling edge, where so has settled
    for (int i = 0; i < n_in; i++) begin
      sclk <= 1'b0;
      si   <= ~si;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      din     = {din[30:0], so};
      oe_seen = oe_seen | so_oe;
      @(posedge ref_clk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // fidrw_host

// file: testbench/fidrw_core_tb.sv
`timescale 1ns/1ps
// self-checking bench for the id, reset and latch opcode decoder
module fidrw_core_tb;
  import fidrw_pkg::*;

  localparam logic [7:0] MK = 8'h5a; // arbitrary value
  localparam logic [7:0] TY = 8'h3c; // arbitrary value
  localparam logic [7:0] DV = 8'h07; // arbitrary value

  logic       ref_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic       busy    = 1'b0;
  logic       op_done = 1'b0;
  logic       cs_n, sclk, si, so, so_oe;
  logic       write_latch_flag, otp_mode, guard_lock, soft_reset, prog_go;
  logic [7:0] prog_op;
  int         err_count = 0;
  int         n_tests   = 0;
  int         sr_cnt    = 0;
  int         pg_cnt    = 0;
  logic [7:0] prog_ops [8] = '{8'h02, 8'h38, 8'h20, 8'h52,
                               8'hd8, 8'h60, 8'hc7, 8'h01};

  always #25 ref_clk = ~ref_clk;

  fidrw_core #(.ID_MAKER(MK), .ID_TYPE(TY), .ID_DEVICE(DV)) fidrw_core_inst (
    .ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so), .so_oe(so_oe), .busy(busy), .op_done(op_done),
    .write_latch_flag(write_latch_flag), .otp_mode(otp_mode),
    .guard_lock(guard_lock), .soft_reset(soft_reset), .prog_go(prog_go),
    .prog_op(prog_op));

  fidrw_host fidrw_host_inst (
    .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
    .so_oe(so_oe));

  // one-cycle pulses are counted as they stand
  always @(posedge ref_clk) begin
    if (soft_reset === 1'b1) sr_cnt++;
    if (prog_go === 1'b1) pg_cnt++;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // single-byte frame, nothing read back; callers send defined codes only
  task automatic cmd(input logic [7:0] op);
    logic [31:0] d;
    logic        o;
    fidrw_host_inst.xfer({24'h0, op}, 8, 0, d, o);
  endtask

  task automatic pulse_done;
    @(posedge ref_clk);
    op_done <= 1'b1;
    @(posedge ref_clk);
    op_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_reset_values;
    chk_bit(write_latch_flag, 1'b0);
    chk_bit(otp_mode, 1'b0);
    chk_bit(guard_lock, 1'b0);
    chk_bit(so_oe, 1'b0);
  endtask

  // arm, clear, arm with a stray clock, clear by completion and suspend
  task automatic t_latch;
    logic [31:0] d;
    logic        o;
    cmd(8'h06);
    chk_bit(write_latch_flag, 1'b1);
    cmd(8'h04);
    chk_bit(write_latch_flag, 1'b0);
    fidrw_host_inst.xfer({23'h0, 8'h06, 1'b0}, 9, 0, d, o);
    chk_bit(write_latch_flag, 1'b0);
    cmd(8'h06);
    pulse_done();
    chk_bit(write_latch_flag, 1'b0);
    cmd(8'h06);
    cmd(8'h75);
    chk_bit(write_latch_flag, 1'b0);
    cmd(8'h06);
    cmd(8'hb0);
    chk_bit(write_latch_flag, 1'b0);
  endtask

  // id stream wraps, early stop, then ignored while the array is busy
  task automatic t_id;
    logic [31:0] d;
    logic        o;
    fidrw_host_inst.xfer(32'h9f, 8, 32, d, o);
    chk_word(d, {MK, TY, DV, MK});
    chk_bit(o, 1'b1);
    fidrw_host_inst.xfer(32'h9f, 8, 12, d, o);
    chk_word(d, {20'h0, MK, TY[7:4]});
    fidrw_host_inst.xfer(32'h9f, 8, 24, d, o);
    chk_word(d, {8'h0, MK, TY, DV});
    busy <= 1'b1;
    fidrw_host_inst.xfer(32'h9f, 8, 16, d, o);
    chk_bit(o, 1'b0);
    busy <= 1'b0;
  endtask

  // signature byte repeats; maker/part order follows address bit 0
  task automatic t_sig_maker_part_read_cmd;
    logic [31:0] d;
    logic        o;
    fidrw_host_inst.xfer({8'hab, 24'h0}, 32, 16, d, o);
    chk_word(d, {16'h0, DV, DV});
    fidrw_host_inst.xfer({8'h90, 24'h0}, 32, 24, d, o);
    chk_word(d, {8'h0, MK, DV, MK});
    fidrw_host_inst.xfer({8'h90, 24'h1}, 32, 24, d, o);
    chk_word(d, {8'h0, DV, MK, DV});
  endtask

  // otp mode and the one-way lock bit
  task automatic t_otp_guard;
    logic [31:0] d;
    logic        o;
    cmd(8'hb1);
    chk_bit(otp_mode, 1'b1);
    cmd(8'hc1);
    chk_bit(otp_mode, 1'b0);
    fidrw_host_inst.xfer(32'h2b, 8, 8, d, o);
    chk_word(d, 32'h0);
    cmd(8'h06);
    cmd(8'h2f);
    chk_bit(guard_lock, 1'b1);
    chk_bit(write_latch_flag, 1'b0);
    fidrw_host_inst.xfer(32'h2b, 8, 16, d, o);
    chk_word(d, 32'h0202);
  endtask

  // reset only when 99 directly follows 66
  task automatic t_soft_reset;
    int n0;
    cmd(8'h06);
    cmd(8'hb1);
    n0 = sr_cnt;
    cmd(8'h66);
    cmd(8'h99);
    chk_word(32'(sr_cnt - n0), 32'h1);
    chk_bit(write_latch_flag, 1'b0);
    chk_bit(otp_mode, 1'b0);
    cmd(8'h66);
    cmd(8'h06);
    cmd(8'h99);
    chk_word(32'(sr_cnt - n0), 32'h1);
    chk_bit(write_latch_flag, 1'b1);
    cmd(8'h04);
  endtask

  // every modifying opcode: refused unarmed, accepted once armed
  task automatic t_prog;
    int n0;
    foreach (prog_ops[i]) begin
      n0 = pg_cnt;
      cmd(prog_ops[i]);
      chk_word(32'(pg_cnt - n0), 32'h0);
      cmd(8'h06);
      cmd(prog_ops[i]);
      chk_word(32'(pg_cnt - n0), 32'h1);
      chk_word({24'h0, prog_op}, {24'h0, prog_ops[i]});
      pulse_done();
      chk_bit(write_latch_flag, 1'b0);
    end
  endtask

  // the run is cut short if a frame never ends
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset_values();
    t_latch();
    t_id();
    t_sig_maker_part_read_cmd();
    t_otp_guard();
    t_soft_reset();
    t_prog();
    stop_test();
  end
endmodule // fidrw_core_tb
